// ===== rtl/otoc_cfg.svh
// Register offsets, field positions, reset values and PRBS seeds.
`ifndef OTOC_CFG_SVH
`define OTOC_CFG_SVH
`define OFS_PAT_SEL 4'h2
`define OFS_SER_GAIN 4'h3
`define OFS_OFFSET_PAT 4'h4
`define OFS_CUSTOM 4'h5
`define OFS_STATUS 4'h6
`define RST_REG 16'h0000
`define POS_FCLK_PAT 13
`define POS_DATA_PAT 7
`define POS_DELAY_LO 0
`define POS_SER_FACTOR 13
`define POS_GAIN_EN 12
`define POS_DELAY_HI 9
`define POS_OFS_EN 8
`define POS_WR_SEL 5
`define POS_AUTO_EN 15
`define POS_START_SRC 14
`define POS_START_MAN 13
`define POS_ACC_CNT 9
`define POS_IND_LANES 8
`define POS_PR_HOLD 7
`define POS_PR_LEN 6
`define POS_PR_ON 5
`define POS_MSB_FIRST 4
`define POS_RES 0
`define PR23_SEED 23'h7fffff
`define PR9_SEED 9'h1ff
`endif

// ===== rtl/otoc_pkg.sv
// Types shared by the output test and offset control block.
package otoc_pkg;
	typedef enum logic [2:0] {
		PAT_NORMAL = 3'h0, PAT_SYNC = 3'h1, PAT_DESKEW = 3'h2,
		PAT_CUSTOM = 3'h3, PAT_ONES = 3'h4, PAT_TOGGLE = 3'h5,
		PAT_ZEROS = 3'h6, PAT_RAMP = 3'h7
	} pattern_type;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0, ST_DELAY = 2'h1, ST_ACCUM = 2'h3
	} corr_state_type;
	typedef struct packed {
		logic [4:0] factor;
		logic [3:0] resolution;
		logic msb_first;
		logic gain_on;
		logic offset_on;
	} path_cfg_type;
endpackage : otoc_pkg

// ===== rtl/output_test_and_offset_control.sv
// Configuration registers, pattern and PRBS generator, offset start control.
`timescale 1ns/1ps
`include "otoc_cfg.svh"
module output_test_and_offset_control #(
	parameter int LANES = 4
) (
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	input wire logic [3:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	input wire logic [3:0] I_AVS_BYTEENABLE,
	output logic [31:0] O_AVS_READDATA,
	output logic O_AVS_WAITREQUEST,
	input wire logic I_TRANSMIT_TRIGGER,
	input wire logic [3*LANES-1:0] I_PER_LANE_PATTERN_SELECT,
	input wire logic [13:0] I_SAMPLE,
	output logic [16*LANES-1:0] O_LANE_WORD,
	output logic [15:0] O_FRAME_WORD,
	output otoc_pkg::path_cfg_type O_PATH_CFG,
	output logic O_LANE_WRITE_SELECT,
	output logic O_CORR_ACCUMULATE,
	output logic O_CORR_DONE
);
	// The lane select and lane word buses are sized for at most sixteen
	// lanes, and at least one lane must exist.
	generate
		if (LANES < 1 || LANES > 16) begin : g_lanes_check
			$error("LANES must lie in 1 to 16");
		end
	endgenerate

	// Software-visible configuration words, then ramp, PRBS, toggle, bus and trigger state.
	logic [15:0] pat_sel_reg;
	logic [15:0] ser_gain_reg;
	logic [15:0] offset_pat_reg;
	logic [15:0] custom_reg;
	logic [15:0] ramp_reg;
	logic [22:0] pr_reg;
	logic pr_len_prev_reg;
	logic toggle_reg;
	logic ack_reg;
	logic trig_meta_reg;
	logic trig_sync_reg;
	logic trig_prev_reg;
	logic start_man_prev_reg;
	// Offset correction sequencer.
	otoc_pkg::corr_state_type state_reg;
	logic [7:0] delay_cnt_reg;
	logic [4:0] acc_cnt_reg;
	logic done_reg;
	logic access;
	logic wr_hit;
	logic [15:0] wdata;
	logic [7:0] delay_val;
	logic start_event;
	logic trig_pulse;
	logic [15:0] pr_word;
	wire logic [16*LANES-1:0] lane_next;

	// Byte-lane merge for a 16-bit register written through a 32-bit bus.
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [15:0] nw, input logic [3:0] be);
		merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
	endfunction : merge

	// Pattern decode shared by the frame lane and every data lane.
	// With the generator on, custom and ramp codes carry its word instead.
	function automatic logic [15:0] pattern_word(input logic [2:0] code,
		input logic [15:0] sample, input logic [15:0] custom,
		input logic [15:0] ramp, input logic tog, input logic [15:0] prw,
		input logic pr_on);
		case (otoc_pkg::pattern_type'(code))
			otoc_pkg::PAT_NORMAL: pattern_word = sample;
			otoc_pkg::PAT_SYNC: pattern_word = 16'hff00;
			otoc_pkg::PAT_DESKEW: pattern_word = 16'haaaa;
			otoc_pkg::PAT_CUSTOM: pattern_word = pr_on ? prw : custom;
			otoc_pkg::PAT_ONES: pattern_word = 16'hffff;
			otoc_pkg::PAT_TOGGLE: pattern_word = tog ? 16'haaaa : 16'h5555;
			otoc_pkg::PAT_ZEROS: pattern_word = 16'h0000;
			otoc_pkg::PAT_RAMP: pattern_word = pr_on ? prw : ramp;
			default: pattern_word = sample;
		endcase
	endfunction : pattern_word

	// A request is taken while no answer is pending; a write lands only
	// at the edge where the master sees waitrequest low, so a request
	// withdrawn before its answer leaves the registers untouched.
	assign access = (I_AVS_READ || I_AVS_WRITE) && !ack_reg;
	assign wr_hit = I_AVS_WRITE && ack_reg;
	assign wdata = I_AVS_WRITEDATA[15:0];

	// One wait cycle per access: waitrequest drops in the second cycle
	// and rises again at once, so back-to-back requests each take two.
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			ack_reg <= 1'b0;
			O_AVS_WAITREQUEST <= 1'b1;
		end else begin
			ack_reg <= access;
			O_AVS_WAITREQUEST <= !access;
		end
	end

	// Read data is captured when the request is taken and then stands
	// through the answer cycle until the next read replaces it.
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			O_AVS_READDATA <= 32'h0;
		end else if (I_AVS_READ && !ack_reg) begin
			case (I_AVS_ADDRESS)
				`OFS_PAT_SEL: O_AVS_READDATA <= {16'h0, pat_sel_reg};
				`OFS_SER_GAIN: O_AVS_READDATA <= {16'h0, ser_gain_reg};
				`OFS_OFFSET_PAT: O_AVS_READDATA <= {16'h0, offset_pat_reg};
				`OFS_CUSTOM: O_AVS_READDATA <= {16'h0, custom_reg};
				// Status: bit 2 done, bits 1:0 the sequencer state.
				`OFS_STATUS: O_AVS_READDATA <= {29'h0, done_reg,
					state_reg};
				default: O_AVS_READDATA <= 32'h0;
			endcase
		end
	end

	// Byte enables 1:0 pick the register halves; enables 3:2 are unused.
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			pat_sel_reg <= `RST_REG;
			ser_gain_reg <= `RST_REG;
			offset_pat_reg <= `RST_REG;
			custom_reg <= `RST_REG;
		end else if (wr_hit) begin
			case (I_AVS_ADDRESS)
				`OFS_PAT_SEL: pat_sel_reg <= merge(pat_sel_reg, wdata,
					I_AVS_BYTEENABLE);
				`OFS_SER_GAIN: ser_gain_reg <= merge(ser_gain_reg, wdata,
					I_AVS_BYTEENABLE);
				`OFS_OFFSET_PAT: offset_pat_reg <= merge(offset_pat_reg,
					wdata, I_AVS_BYTEENABLE);
				`OFS_CUSTOM: custom_reg <= merge(custom_reg, wdata,
					I_AVS_BYTEENABLE);
				default: ;
			endcase
		end
	end

	// Path configuration as plain counts; reserved rate and resolution
	// codes fall back to twelve so the serializer never sees a bad width.
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			O_PATH_CFG <= '0;
			O_LANE_WRITE_SELECT <= 1'b0;
		end else begin
			case (ser_gain_reg[`POS_SER_FACTOR +: 3])
				3'h1: O_PATH_CFG.factor <= 5'd14;
				3'h4: O_PATH_CFG.factor <= 5'd16;
				3'h3: O_PATH_CFG.factor <= 5'd10;
				default: O_PATH_CFG.factor <= 5'd12;
			endcase
			case (offset_pat_reg[`POS_RES +: 2])
				2'h1: O_PATH_CFG.resolution <= 4'd14;
				2'h3: O_PATH_CFG.resolution <= 4'd10;
				default: O_PATH_CFG.resolution <= 4'd12;
			endcase
			O_PATH_CFG.msb_first <= offset_pat_reg[`POS_MSB_FIRST];
			O_PATH_CFG.gain_on <= ser_gain_reg[`POS_GAIN_EN];
			O_PATH_CFG.offset_on <= ser_gain_reg[`POS_OFS_EN];
			O_LANE_WRITE_SELECT <= ser_gain_reg[`POS_WR_SEL];
		end
	end

	// Trigger pin synchroniser and rising-edge detect. Only the second
	// stage feeds logic; a pin edge is seen two clocks after it rises.
	// The manual start bit has its own edge detect, so a bit left at one
	// does not restart the correction each time it finishes.
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			trig_meta_reg <= 1'b0;
			trig_sync_reg <= 1'b0;
			trig_prev_reg <= 1'b0;
			start_man_prev_reg <= 1'b0;
		end else begin
			trig_meta_reg <= I_TRANSMIT_TRIGGER;
			trig_sync_reg <= trig_meta_reg;
			trig_prev_reg <= trig_sync_reg;
			start_man_prev_reg <= offset_pat_reg[`POS_START_MAN];
		end
	end

	assign trig_pulse = trig_sync_reg && !trig_prev_reg;
	// The start delay joins two high bits of one register to the six low
	// bits of the pattern register.
	assign delay_val = {ser_gain_reg[`POS_DELAY_HI +: 2],
		pat_sel_reg[`POS_DELAY_LO +: 6]};
	assign start_event = offset_pat_reg[`POS_START_SRC] ? trig_pulse
		: (offset_pat_reg[`POS_START_MAN] && !start_man_prev_reg);

	// Correction sequencer; new starts are ignored while busy. A manual
	// start skips the delay, which only counts from a trigger pulse. The
	// accumulate phase lasts the programmed field plus one samples.
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			state_reg <= otoc_pkg::ST_IDLE;
			delay_cnt_reg <= 8'h0;
			acc_cnt_reg <= 5'h0;
			done_reg <= 1'b0;
		end else if (!offset_pat_reg[`POS_AUTO_EN]) begin
			state_reg <= otoc_pkg::ST_IDLE;
			done_reg <= 1'b0;
		end else begin
			case (state_reg)
				otoc_pkg::ST_IDLE: begin
					if (start_event) begin
						done_reg <= 1'b0;
						delay_cnt_reg <= offset_pat_reg[`POS_START_SRC]
							? delay_val : 8'h0;
						state_reg <= otoc_pkg::ST_DELAY;
					end
				end
				otoc_pkg::ST_DELAY: begin
					if (delay_cnt_reg == 8'h0) begin
						acc_cnt_reg <= {1'b0,
							offset_pat_reg[`POS_ACC_CNT +: 4]} + 5'h1;
						state_reg <= otoc_pkg::ST_ACCUM;
					end else begin
						delay_cnt_reg <= delay_cnt_reg - 8'h1;
					end
				end
				otoc_pkg::ST_ACCUM: begin
					if (acc_cnt_reg == 5'h1) begin
						done_reg <= 1'b1;
						state_reg <= otoc_pkg::ST_IDLE;
					end
					acc_cnt_reg <= acc_cnt_reg - 5'h1;
				end
				default: state_reg <= otoc_pkg::ST_IDLE;
			endcase
		end
	end

	// Registered copies keep every correction output straight from a flop.
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			O_CORR_ACCUMULATE <= 1'b0;
			O_CORR_DONE <= 1'b0;
		end else begin
			O_CORR_ACCUMULATE <= state_reg == otoc_pkg::ST_ACCUM;
			O_CORR_DONE <= done_reg;
		end
	end

	// PRBS: 23-bit x^23+x^18+1 or 9-bit x^9+x^5+1. A change of length
	// reseeds the register: the short generator keeps only the low bits
	// of the long one, which may all be zero and would lock it up.
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST || offset_pat_reg[`POS_PR_HOLD]) begin
			pr_reg <= `PR23_SEED;
			pr_len_prev_reg <= offset_pat_reg[`POS_PR_LEN];
		end else if (offset_pat_reg[`POS_PR_LEN]
			!= pr_len_prev_reg) begin
			pr_reg <= offset_pat_reg[`POS_PR_LEN] ? {14'h0, `PR9_SEED}
				: `PR23_SEED;
			pr_len_prev_reg <= offset_pat_reg[`POS_PR_LEN];
		end else if (offset_pat_reg[`POS_PR_ON]) begin
			if (offset_pat_reg[`POS_PR_LEN]) begin
				pr_reg <= {14'h0, pr_reg[7:0], pr_reg[8] ^ pr_reg[4]};
			end else begin
				pr_reg <= {pr_reg[21:0], pr_reg[22] ^ pr_reg[17]};
			end
		end
	end

	assign pr_word = offset_pat_reg[`POS_PR_LEN] ? {7'h0, pr_reg[8:0]}
		: pr_reg[15:0];

	// Ramp and toggle run free so that every lane using them stays in step.
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			ramp_reg <= 16'h0;
			toggle_reg <= 1'b0;
		end else begin
			ramp_reg <= ramp_reg + 16'h1;
			toggle_reg <= !toggle_reg;
		end
	end

	// The frame line carries half ones, half zeros in normal operation,
	// which is the sync word, so its normal input is that constant.
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			O_FRAME_WORD <= 16'h0;
		end else begin
			O_FRAME_WORD <= pattern_word(pat_sel_reg[`POS_FCLK_PAT +: 3],
				16'hff00, custom_reg, ramp_reg, toggle_reg, pr_word,
				offset_pat_reg[`POS_PR_ON]);
		end
	end

	// Each lane picks its own code only in independent mode. The words are
	// formed first and registered in one process, so one process drives
	// the whole output bus.
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : lane
			logic [2:0] code;
			assign code = offset_pat_reg[`POS_IND_LANES]
				? I_PER_LANE_PATTERN_SELECT[3*g +: 3]
				: pat_sel_reg[`POS_DATA_PAT +: 3];
			assign lane_next[16*g +: 16] = pattern_word(code,
				{2'h0, I_SAMPLE}, custom_reg, ramp_reg, toggle_reg,
				pr_word, offset_pat_reg[`POS_PR_ON]);
		end
	endgenerate

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			O_LANE_WORD <= '0;
		end else begin
			O_LANE_WORD <= lane_next;
		end
	end
endmodule : output_test_and_offset_control

// ===== testbench/otoc_checker.sv
// Assertions on bus answers, configuration codes and correction timing.
`timescale 1ns/1ps
module otoc_checker (
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic O_AVS_WAITREQUEST,
	input wire otoc_pkg::path_cfg_type O_PATH_CFG,
	input wire logic O_CORR_ACCUMULATE,
	input wire logic O_CORR_DONE
);
	default clocking dc @(posedge I_CLK);
	endclocking
	default disable iff (I_SYS_RST);
	wire logic rq = I_AVS_READ || I_AVS_WRITE;
	property p_ans; rq && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST;
	endproperty
	a_ans: assert property (p_ans) else $error("bus answer late");
	property p_one; !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST;
	endproperty
	a_one: assert property (p_one) else $error("answer held too long");
	property p_cause; $fell(O_AVS_WAITREQUEST) |-> $past(rq);
	endproperty
	a_cause: assert property (p_cause) else $error("answer without request");
	property p_fac; !$past(I_SYS_RST) && !$past(I_SYS_RST, 2) |->
		O_PATH_CFG.factor inside {5'h0a, 5'h0c, 5'h0e, 5'h10};
	endproperty
	a_fac: assert property (p_fac) else $error("bad factor");
	property p_res; !$past(I_SYS_RST) && !$past(I_SYS_RST, 2) |->
		O_PATH_CFG.resolution inside {4'ha, 4'hc, 4'he};
	endproperty
	a_res: assert property (p_res) else $error("bad resolution");
	property p_len; $rose(O_CORR_ACCUMULATE) |-> ##[1:16] !O_CORR_ACCUMULATE;
	endproperty
	a_len: assert property (p_len) else $error("accumulation too long");
	property p_done; $fell(O_CORR_ACCUMULATE) |-> ##[0:1] O_CORR_DONE;
	endproperty
	a_done: assert property (p_done) else $error("done missing");
	property p_src; $rose(O_CORR_DONE) |-> $past(O_CORR_ACCUMULATE);
	endproperty
	a_src: assert property (p_src) else $error("done without accumulation");
endmodule : otoc_checker

// ===== testbench/otoc_rx_model.sv
// Receiver model that captures lanes 0 and 1 and the frame line each sample.
`timescale 1ns/1ps
module otoc_rx_model (
	input wire logic i_clk,
	input wire logic [63:0] i_lane_word,
	input wire logic [15:0] i_frame_word,
	output logic [15:0] o_lane0,
	output logic [15:0] o_lane1,
	output logic [15:0] o_frame
);
	always_ff @(posedge i_clk) begin
		o_lane0 <= i_lane_word[15:0];
		o_lane1 <= i_lane_word[31:16];
		o_frame <= i_frame_word;
	end
endmodule : otoc_rx_model

// ===== testbench/tb_top.sv
// Register, pattern and offset correction tests for the output block.
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic trig = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [11:0] lsel = 12'h034;
	logic [13:0] smp = 14'h2abc;
	logic [31:0] rdata;
	logic wreq, wsel, acc, done;
	logic [63:0] lanes;
	logic [15:0] frame, r0, r1, rf, q, pa;
	otoc_pkg::path_cfg_type cfg;
	int error_cnt = 0;
	int tests_run = 0;
	int i, w, n;
	logic [15:0] pe [8] = '{16'h0, 16'hff00, 16'haaaa, 16'h1234,
		16'hffff, 16'h0, 16'h0, 16'h0};
	logic [4:0] fx [8] = '{5'h0c, 5'h0e, 5'h0c, 5'h0a,
		5'h10, 5'h0c, 5'h0c, 5'h0c};
	logic [3:0] rx [4] = '{4'hc, 4'he, 4'hc, 4'ha};
	output_test_and_offset_control i_output_test_and_offset_control (
		.I_CLK(clk), .I_SYS_RST(rst), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
		.I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(4'h3),
		.O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq),
		.I_TRANSMIT_TRIGGER(trig), .I_PER_LANE_PATTERN_SELECT(lsel),
		.I_SAMPLE(smp), .O_LANE_WORD(lanes), .O_FRAME_WORD(frame),
		.O_PATH_CFG(cfg), .O_LANE_WRITE_SELECT(wsel),
		.O_CORR_ACCUMULATE(acc), .O_CORR_DONE(done));
	otoc_rx_model i_otoc_rx_model (.i_clk(clk), .i_lane_word(lanes),
		.i_frame_word(frame), .o_lane0(r0), .o_lane1(r1), .o_frame(rf));
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One Avalon transfer; the request stands until waitrequest is seen low.
	task automatic bus(input logic wn, input logic [3:0] a,
		input logic [15:0] d);
		int k;
		k = 0;
		@(posedge clk);
		addr <= a;
		wdata <= {16'h0, d};
		wr <= wn;
		rd <= ~wn;
		do begin
			@(posedge clk);
			k++;
		end while (wreq !== 1'b0 && k < 20);
		q = rdata[15:0];
		rd <= 1'b0;
		wr <= 1'b0;
		if (wreq !== 1'b0) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask : bus
	task automatic acc_len();
		w = 0;
		n = 0;
		while (acc !== 1'b1 && w < 300) begin
			@(posedge clk);
			w++;
		end
		while (acc === 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		if (w == 300 || n == 40) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask : acc_len
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 7; i++) begin
			bus(1'b0, i[3:0], 16'h0);
			chk("reset", 16'h0, q);
		end
		chk("normal0", 16'h2abc, r0);
		chk("normal2", 16'h2abc, lanes[47:32]);
		chk("fnormal", 16'hff00, rf);
		bus(1'b1, 4'h1, 16'hffff);
		bus(1'b0, 4'h1, 16'h0);
		chk("unmapped", 16'h0, q);
		for (i = 0; i < 8; i++) begin
			pa = {i[2:0], i[0], 3'h0, i[1], 2'h0, i[2], 5'h0};
			bus(1'b1, 4'h3, pa);
			bus(1'b0, 4'h3, 16'h0);
			chk("reg3", pa, q);
			chk("cfg3", {8'h0, fx[i], i[0], i[1], i[2]}, {8'h0, cfg.factor,
				cfg.gain_on, cfg.offset_on, wsel});
		end
		for (i = 0; i < 4; i++) begin
			bus(1'b1, 4'h4, {11'h0, i[0], 2'h0, i[1:0]});
			repeat (2) @(posedge clk);
			chk("cfg4", {11'h0, rx[i], i[0]},
				{11'h0, cfg.resolution, cfg.msb_first});
		end
		bus(1'b1, 4'h5, 16'h1234);
		for (i = 1; i < 7; i++) begin
			if (i != 5) begin
				bus(1'b1, 4'h2, {i[2:0], 3'h0, i[2:0], 7'h0});
				repeat (3) @(posedge clk);
				chk("lane0", pe[i], r0);
				chk("lane1", pe[i], r1);
				chk("frame", pe[i], rf);
			end
		end
		bus(1'b1, 4'h2, 16'ha280);
		repeat (3) @(posedge clk);
		pa = r0;
		@(posedge clk);
		chk("toggle", 16'hffff, pa ^ r0);
		chk("tglval", 16'h1, {15'h0, pa == 16'haaaa || pa == 16'h5555});
		bus(1'b1, 4'h2, 16'he380);
		repeat (3) @(posedge clk);
		pa = r0;
		@(posedge clk);
		chk("ramp", pa + 16'h1, r0);
		bus(1'b1, 4'h4, 16'h0100);
		repeat (3) @(posedge clk);
		chk("ind0", 16'hffff, r0);
		chk("ind1", 16'h0000, r1);
		bus(1'b1, 4'h2, 16'h0180);
		bus(1'b1, 4'h4, 16'h00a0);
		repeat (3) @(posedge clk);
		pa = r0;
		@(posedge clk);
		chk("hold", pa, r0);
		for (i = 0; i < 2; i++) begin
			bus(1'b1, 4'h4, {9'h0, i[0], 6'h20});
			repeat (3) @(posedge clk);
			pa = r0;
			@(posedge clk);
			chk("run", 16'h1, {15'h0, pa !== r0});
		end
		bus(1'b1, 4'h4, 16'h0);
		repeat (3) @(posedge clk);
		chk("off", 16'h1234, r0);
		bus(1'b1, 4'h4, 16'h8a00);
		bus(1'b1, 4'h4, 16'haa00);
		acc_len();
		chk("acc", 16'h6, n[15:0]);
		chk("done", 16'h1, {15'h0, done});
		bus(1'b0, 4'h6, 16'h0);
		chk("status", 16'h0004, q);
		bus(1'b1, 4'h2, 16'h0005);
		bus(1'b1, 4'h3, 16'h0200);
		bus(1'b1, 4'h4, 16'hc000);
		// The second pulse falls inside the delay and must not restart it.
		for (i = 0; i < 2; i++) begin
			trig <= 1'b1;
			repeat (2) @(posedge clk);
			trig <= 1'b0;
			repeat (8) @(posedge clk);
		end
		acc_len();
		chk("delay", 16'h1, {15'h0, w >= 45 && w <= 58});
		chk("acc1", 16'h1, n[15:0]);
		tally_and_finish();
	end
endmodule : tb_top
bind output_test_and_offset_control otoc_checker i_otoc_checker (
	.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_AVS_READ(I_AVS_READ),
	.I_AVS_WRITE(I_AVS_WRITE), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
	.O_PATH_CFG(O_PATH_CFG), .O_CORR_ACCUMULATE(O_CORR_ACCUMULATE),
	.O_CORR_DONE(O_CORR_DONE));
